// ===== rtl/mc_core_ctrl.v
// Purpose: host-side sequencer driving a core memory through its pins
// Assumes: 125 MHz clock, memory timing runs from start pulse edges
// Notes: software reaches own registers over a plain strobe port
//
// Contract
// - Host raises start pulse to request
// - Address on L bus, data on W
// - Write data held 550 to 950 ns
// - Half mode needs second start pulse
// - Second half start 475 ns apart
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "mc_defs.vh"
module mc_core_ctrl (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire [4:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  output reg memory_start_pulse_o,
  output reg full_cycle_select_o,
  output reg write_not_read_o,
  output reg protect_enable_o,
  output reg [14:0] address_o,
  input wire [15:0] data_bus_bit_n_i,
  output reg [15:0] data_bus_bit_n_o,
  output reg [15:0] data_bus_bit_n_oe_o
);
  // Timing counts, cut to counter width on purpose
  localparam integer PULSE_I = `MC_PULSE_CYC;
  localparam integer READ_I = `MC_READ_CYC + `MC_SYNC_CYC;
  localparam integer WEND_I = `MC_WEND_CYC;
  localparam integer FULL_I = `MC_WEND_CYC + 1;
  localparam integer HALF_I = `MC_HALF_CYC;
  localparam [7:0] PULSE_CYC = PULSE_I[7:0];
  localparam [7:0] READ_SMP = READ_I[7:0];
  localparam [7:0] WEND_CYC = WEND_I[7:0];
  localparam [7:0] FULL_END = FULL_I[7:0];
  localparam [7:0] HALF_CYC = HALF_I[7:0];

  // One-hot states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_RUN = 4'h2;
  localparam [3:0] ST_HWAIT = 4'h4;
  localparam [3:0] ST_RUN2 = 4'h8;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  reg wnr_reg;
  reg full_reg;
  reg prot_reg;
  reg [14:0] addr_reg;
  reg [15:0] wdata_reg;
  reg [15:0] rdata_reg;
  reg done_reg;
  reg finish;
  reg go;
  reg go2;
  reg drive_en;
  reg start_lvl;
  reg ctrl_wr;
  reg wnr_eff;
  reg full_eff;
  wire [15:0] bus_sync;

  // Pin data arrive from another domain
  mc_sync3 #(.W(16)) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(data_bus_bit_n_i),
    .sync_o(bus_sync)
  );

  // Command decode; a go while busy is ignored
  always @*
  begin
    ctrl_wr = reg_wr_i && (reg_addr_i == {1'b0, `MC_REG_CTRL}) && state_reg[0];
    // Levels written beside GO must reach the pins with the start edge
    wnr_eff = ctrl_wr ? reg_wdata_i[`MC_CTRL_WNR] : wnr_reg;
    full_eff = ctrl_wr ? reg_wdata_i[`MC_CTRL_FULL] : full_reg;
    go = reg_wr_i && (reg_addr_i == {1'b0, `MC_REG_CTRL})
      && reg_wdata_i[`MC_CTRL_GO] && state_reg[0];
    go2 = reg_wr_i && (reg_addr_i == {1'b0, `MC_REG_CTRL})
      && reg_wdata_i[`MC_CTRL_GO2] && state_reg[2];
  end

  // Sequencer: counter stands in for the delay chain
  always @*
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    finish = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (go)
        begin
          state_next = ST_RUN;
          cnt_next = 8'h00;
        end
      end
      ST_RUN:
      begin
        cnt_next = cnt_reg + 8'h01;
        if (full_reg && cnt_reg == FULL_END)
        begin
          state_next = ST_IDLE;
          finish = 1'b1;
        end
        else if (!full_reg && cnt_reg == HALF_CYC)
          state_next = ST_HWAIT;
      end
      ST_HWAIT:
      begin
        // Spacing is already past 475 ns here
        if (go2)
        begin
          state_next = ST_RUN2;
          cnt_next = 8'h00;
        end
      end
      ST_RUN2:
      begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == HALF_CYC)
        begin
          state_next = ST_IDLE;
          finish = 1'b1;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Pin level terms for the next cycle
  always @*
  begin
    start_lvl = (state_next[1] || state_next[3]) && (cnt_next < PULSE_CYC);
    // Host drives W only on writes: from the start edge to the window end, or the whole second half
    drive_en = wnr_eff && ((state_next[1] && full_eff && cnt_next <= WEND_CYC)
      || state_next[3]);
  end

  // State, counter and pins
  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      memory_start_pulse_o <= 1'b0;
      data_bus_bit_n_o <= 16'h0000;
      data_bus_bit_n_oe_o <= 16'h0000;
      rdata_reg <= 16'h0000;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      memory_start_pulse_o <= start_lvl;
      // Active-low open-collector: pull low for a one
      data_bus_bit_n_o <= 16'h0000;
      data_bus_bit_n_oe_o <= drive_en ? wdata_reg : 16'h0000;
      // Capture sensed word after valid time plus sync delay
      if (state_reg[1] && !wnr_reg && cnt_reg == READ_SMP)
        rdata_reg <= ~bus_sync;
      // Set wins over a software clear
      if (finish)
        done_reg <= 1'b1;
      else if (reg_wr_i && reg_addr_i == `MC_REG_STAT && reg_wdata_i[`MC_STAT_DONE])
        done_reg <= 1'b0;
    end
  end

  // Software-written settings; held steady while a cycle runs
  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wnr_reg <= 1'b0;
      full_reg <= 1'b1;
      prot_reg <= 1'b0;
      addr_reg <= 15'h0000;
      wdata_reg <= 16'h0000;
      full_cycle_select_o <= 1'b1;
      write_not_read_o <= 1'b0;
      protect_enable_o <= 1'b0;
      address_o <= 15'h0000;
    end
    else
    begin
      if (reg_wr_i && state_reg[0])
      begin
        if (reg_addr_i == {1'b0, `MC_REG_CTRL})
        begin
          wnr_reg <= reg_wdata_i[`MC_CTRL_WNR];
          full_reg <= reg_wdata_i[`MC_CTRL_FULL];
          prot_reg <= reg_wdata_i[`MC_CTRL_PROT];
        end
        if (reg_addr_i == {1'b0, `MC_REG_ADDR})
          addr_reg <= reg_wdata_i[14:0];
        if (reg_addr_i == {1'b0, `MC_REG_WDATA})
          wdata_reg <= reg_wdata_i[15:0];
      end
      // Pins follow the next settings so the memory sees them at start
      full_cycle_select_o <= full_eff;
      write_not_read_o <= wnr_eff;
      protect_enable_o <= ctrl_wr ? reg_wdata_i[`MC_CTRL_PROT] : prot_reg;
      if (reg_wr_i && state_reg[0] && reg_addr_i == {1'b0, `MC_REG_ADDR})
        address_o <= reg_wdata_i[14:0];
    end
  end

  // Read port: data in the cycle after the strobe
  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        {1'b0, `MC_REG_CTRL}:
          reg_rdata_o <= {27'h0000000, 1'b0, prot_reg, full_reg, wnr_reg, 1'b0};
        {1'b0, `MC_REG_ADDR}:
          reg_rdata_o <= {17'h00000, addr_reg};
        {1'b0, `MC_REG_WDATA}:
          reg_rdata_o <= {16'h0000, wdata_reg};
        {1'b0, `MC_REG_RDATA}:
          reg_rdata_o <= {16'h0000, rdata_reg};
        `MC_REG_STAT:
          reg_rdata_o <= {29'h00000000, done_reg, state_reg[2], !state_reg[0]};
        default:
          reg_rdata_o <= 32'h00000000;
      endcase
    end
    else
      reg_rdata_o <= 32'h00000000;
  end
endmodule // mc_core_ctrl
`default_nettype wire

// ===== shared/mc_defs.vh
// Purpose: constants for the core memory cycle controller
// Assumes: 125 MHz system clock
// Notes: times in ns, cycle counts derived from them
`ifndef MC_DEFS_VH
`define MC_DEFS_VH

// Clock period
`define MC_CLK_NS 8
// Start pulse width (host choice)
`define MC_PULSE_NS 40
`define MC_PULSE_CYC ((`MC_PULSE_NS + `MC_CLK_NS - 1) / `MC_CLK_NS)
// Read data valid after start leading edge
`define MC_READ_NS 420
`define MC_READ_CYC ((`MC_READ_NS + `MC_CLK_NS - 1) / `MC_CLK_NS)
// Extra cycles of the three-stage input synchroniser
`define MC_SYNC_CYC 4
// End of write data window after start leading edge
`define MC_WEND_NS 950
`define MC_WEND_CYC ((`MC_WEND_NS + `MC_CLK_NS - 1) / `MC_CLK_NS)
// Half cycle spacing and duration
`define MC_HALF_NS 475
`define MC_HALF_CYC ((`MC_HALF_NS + `MC_CLK_NS - 1) / `MC_CLK_NS)

// Register byte offsets
`define MC_REG_CTRL 4'h0
`define MC_REG_ADDR 4'h4
`define MC_REG_WDATA 4'h8
`define MC_REG_RDATA 4'hC
// Status sits above the low nibble space, decoded on 5 bits
`define MC_REG_STAT 5'h10

// Control bits
`define MC_CTRL_GO 0
`define MC_CTRL_WNR 1
`define MC_CTRL_FULL 2
`define MC_CTRL_PROT 3
`define MC_CTRL_GO2 4
// Status bits
`define MC_STAT_BUSY 0
`define MC_STAT_HWAIT 1
`define MC_STAT_DONE 2

// Bus widths
`define MC_AW 15
`define MC_DW 16

`endif

// ===== rtl/mc_sync3.v
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to sys_clk_i
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module mc_sync3 #(
  parameter W = 16
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  integer i;

  // First stage feeds only the second
  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end
    else
    begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1)
        if (s2_reg[i] == s3_reg[i])
          sync_o[i] <= s3_reg[i];
    end
  end
endmodule // mc_sync3
`default_nettype wire

// ===== dv/mc_core_ctrl_asserts.sv
// Purpose: port checker for the core memory cycle controller
// Assumes: bound onto mc_core_ctrl
// Notes: sees design outputs except protect_enable_o, plus the register read and write strobes
`timescale 1ns/1ns
`default_nettype none
module mc_core_ctrl_chk (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic memory_start_pulse_o,
  input wire logic full_cycle_select_o,
  input wire logic write_not_read_o,
  input wire logic [14:0] address_o,
  input wire logic [15:0] data_bus_bit_n_o,
  input wire logic [15:0] data_bus_bit_n_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Short alias for the start line
  wire st = memory_start_pulse_o;
  property p_pw; $rose(st) |-> st[*5] ##1 !st; endproperty
  a_pw: assert property (p_pw) else $error("start pulse width");
  property p_go; $rose(st) |-> $past(reg_wr_i); endproperty
  a_go: assert property (p_go) else $error("start without order");
  property p_gap; $fell(st) |=> !st [*8]; endproperty
  a_gap: assert property (p_gap) else $error("start too soon");
  property p_lock;
    st && $past(st) |-> $stable(address_o) && $stable(write_not_read_o)
      && $stable(full_cycle_select_o);
  endproperty
  a_lock: assert property (p_lock) else $error("levels moved");
  property p_rd0; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("stray read data");
  property p_oc; data_bus_bit_n_o == 16'h0; endproperty
  a_oc: assert property (p_oc) else $error("bus driven high");
  property p_nrd; !write_not_read_o |-> data_bus_bit_n_oe_o == 16'h0; endproperty
  a_nrd: assert property (p_nrd) else $error("bus pulled in read");
  // Write word must hold deep into the store window
  property p_hold;
    $rose(st) && write_not_read_o && full_cycle_select_o
      |-> ##110 data_bus_bit_n_oe_o == $past(data_bus_bit_n_oe_o, 110);
  endproperty
  a_hold: assert property (p_hold) else $error("write word dropped");
  c_full: cover property ($rose(st) && full_cycle_select_o && write_not_read_o);
  c_half: cover property ($rose(st) && !full_cycle_select_o);
  c_read: cover property (reg_rd_i ##1 reg_rdata_o != 32'h0);
endmodule // mc_core_ctrl_chk
bind mc_core_ctrl mc_core_ctrl_chk i_chk (.*);
`default_nettype wire

// ===== dv/mc_mem_model.sv
// Purpose: behavioural core memory facing the controller
// Assumes: W bus pulled up, bits active low, open collector
// Notes: 256 words indexed by the low address byte
`timescale 1ns/1ns
`default_nettype none
module mc_mem_model #(
  parameter [2:0] TOP = 3'h7,
  parameter [2:0] FOLD = 3'h0
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic full_i,
  input wire logic wnr_i,
  input wire logic prot_i,
  input wire logic [14:0] addr_i,
  input wire logic [15:0] bus_n_i,
  output logic [15:0] oe_o
);
  reg [15:0] mem [0:255];
  reg [7:0] cnt;
  reg run, prev, hw, sec, wph;
  // Grounded high address lines fold onto installed memory
  wire [14:0] fa = {addr_i[14:12] & ~FOLD, addr_i[11:0]};
  // Increments above the top one do not answer
  wire here = fa[14:12] <= TOP;
  // Loader area of the last increment, only while enabled
  wire lock = prot_i && fa[11:8] == 4'hF && fa[14:12] == TOP;
  // Sense strobe only on a read first half
  wire strobe = run && cnt == 8'h28 && !wnr_i && !sec;
  // Delay chain kept as a counter from the start edge
  always @(posedge sys_clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      {cnt, run, prev, hw, sec, wph, oe_o} <= 29'h0;
    end
    else
    begin
      prev <= start_i;
      if (start_i && !prev)
      begin
        cnt <= 8'h00;
        run <= 1'b1;
        sec <= !full_i && hw;
        hw <= !full_i && !hw;
        wph <= 1'b0;
      end
      else if (run)
        cnt <= cnt + 8'h01;
      // Write phase begins after the last tap of the first half
      if (run && cnt == 8'h3D)
        wph <= 1'b1;
      if (strobe)
        oe_o <= here ? mem[fa[7:0]] : 16'h0000;
      if (cnt == 8'h3E)
        oe_o <= 16'h0000; // Released, pull-up takes the line
      if (run && wnr_i && !lock && here && (full_i ? wph : sec)
        && cnt == (sec ? 8'h1E : 8'h64))
        mem[fa[7:0]] <= ~bus_n_i;
      if (cnt == 8'h6E || (cnt == 8'h3E && !full_i))
        run <= 1'b0;
    end
endmodule // mc_mem_model
`default_nettype wire

// ===== dv/test_mc_core_ctrl.sv
// Purpose: self-checking bench for the core memory cycle controller
// Assumes: memory model on the far side of a pulled-up bus
// Notes: seeded random words plus corner cases
`timescale 1ns/1ns
`default_nettype none
`include "mc_defs.vh"
module test_mc_core_ctrl;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [4:0] a = 5'h00;
  logic [31:0] wd = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  wire [31:0] rdat;
  wire st, fc, wn, pe;
  wire [14:0] ad;
  wire [15:0] dn, doe, moe;
  wire [15:0] bus_n = ~(doe | moe); // Any puller wins over the pull-up
  integer errors = 0;
  integer checked = 0;
  integer i, n;
  logic [31:0] s;
  logic [15:0] d;
  logic [14:0] x;
  mc_core_ctrl i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(a),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .memory_start_pulse_o(st), .full_cycle_select_o(fc), .write_not_read_o(wn),
    .protect_enable_o(pe), .address_o(ad), .data_bus_bit_n_i(bus_n),
    .data_bus_bit_n_o(dn), .data_bus_bit_n_oe_o(doe));
  mc_mem_model i_mem (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .start_i(st),
    .full_i(fc), .wnr_i(wn), .prot_i(pe), .addr_i(ad), .bus_n_i(bus_n), .oe_o(moe));
  // Protected writes leave the old word
  function [15:0] f_exp(input [15:0] o, input [15:0] v, input [14:0] w, input p);
    f_exp = (p && w[11:8] == 4'hF && w[14:12] == 3'h7) ? o : v;
  endfunction
  task chk(input [31:0] v, input [31:0] e);
  begin
    checked = checked + 1;
    if (v !== e)
    begin
      errors = errors + 1;
      $display("ERROR t=%0t seen %h exp %h", $time, v, e);
    end
  end
  endtask
  task wrt(input [4:0] r, input [31:0] v);
  begin
    @(posedge sys_clk_i);
    a <= r;
    wd <= v;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  end
  endtask
  task rdt(input [4:0] r);
  begin
    @(posedge sys_clk_i);
    a <= r;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 s = rdat;
  end
  endtask
  // One access; m is protect, full, write
  task op(input [14:0] w, input [15:0] v, input [2:0] m);
  begin
    wrt({1'b0, `MC_REG_ADDR}, {17'h0, w});
    wrt({1'b0, `MC_REG_WDATA}, {16'h0, v});
    wrt({1'b0, `MC_REG_CTRL}, {28'h0, m, 1'b1});
    s = 32'h0;
    for (i = 0; i < 200 && s[`MC_STAT_DONE] !== 1'b1; i = i + 1)
    begin
      rdt(`MC_REG_STAT);
      if (s[`MC_STAT_HWAIT] === 1'b1)
        wrt({1'b0, `MC_REG_CTRL}, {28'h1, m, 1'b0});
    end
    chk({31'h0, s[`MC_STAT_DONE]}, 32'h1);
    wrt(`MC_REG_STAT, 32'h4);
  end
  endtask
  task end_of_test;
  begin
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  initial
    forever #4 sys_clk_i = ~sys_clk_i;
  initial
  begin
    #400000;
    errors = errors + 1;
    end_of_test;
  end
  initial
  begin
    d = $urandom(36839);
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rdt(`MC_REG_STAT);
    chk(s, 32'h0);
    chk({31'h0, fc}, 32'h1);
    // Write then read back, full and half cycles mixed
    for (n = 0; n < 6; n = n + 1)
    begin
      x = $urandom;
      d = (n < 2) ? {16{n[0]}} : $urandom;
      op(x, d, {2'b00, ~n[0]} + 3'h2 * n[0] + 3'h1 * n[0]);
      op(x, 16'h0, {1'b0, ~n[1], 1'b0});
      chk({17'h0, ad}, {17'h0, x});
      rdt({1'b0, `MC_REG_RDATA});
      chk(s, {16'h0, d});
      $display("test %0d done", n);
    end
    // Loader area: plain write, then a blocked one
    x = 15'h7F3C;
    for (n = 0; n < 2; n = n + 1)
    begin
      d = n[0] ? 16'hBEEF : 16'h1234;
      op(x, d, {n[0], 2'b11});
      op(x, 16'h0, {n[0], 2'b10});
      rdt({1'b0, `MC_REG_RDATA});
      chk(s, {16'h0, f_exp(16'h1234, d, x, n[0])});
      $display("protect test %0d done", n);
    end
    chk({31'h0, pe}, 32'h1);
    chk({31'h0, wn}, 32'h0);
    rdt({1'b0, `MC_REG_CTRL});
    chk(s, 32'hC);
    rdt(5'h14);
    chk(s, 32'h0);
    end_of_test;
  end
endmodule // test_mc_core_ctrl
`default_nettype wire
